// file: dv/fbms_station_model.sv
// fbms_station_model: behavioural set of fieldbus slave stations facing the status bank
module fbms_station_model import fbms_pkg::*; (
    input wire logic i_clk,
    input wire logic [FBMS_STATIONS-1:0] i_present,
    input wire logic i_fire,
    output logic [FBMS_STATIONS-1:0] o_online,
    output logic [FBMS_STATIONS-1:0] o_exch,
    output logic [FBMS_STATIONS-1:0] o_alarm,
    output logic [FBMS_STATIONS-1:0] o_diag
);
    timeunit 1ns;
    timeprecision 1ps;
    // only even stations exchange, so odd ones expose the slave error path
    always_ff @(posedge i_clk) begin
        o_online <= i_present;
        o_exch <= i_present & {1'b1, {63{2'b01}}};
        o_alarm <= i_fire ? i_present : '0;
        o_diag <= i_fire ? i_present : '0;
    end
endmodule // fbms_station_model

// file: dv/fbms_status_bank_tb.sv
// fbms_status_bank_tb: register-level test of the status bank over AXI4-Lite
module fbms_status_bank_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import fbms_pkg::*;
    logic i_clk = 0, i_reset = 1, i_net_fault = 0, fire = 0;
    logic [126:0] expct = '0, present = '0, onl, exch, alm, dg;
    logic [7:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rdata, rd;
    logic [3:0] wstrb = 0;
    logic awv = 0, wv = 0, bready = 0, arv = 0, rready = 0;
    logic awr, wr_rdy, bv, arr, rv, irq;
    logic [1:0] bresp, rresp, rs;
    logic [15:0] crc;
    int error_cnt = 0, n_checks = 0, cyc = 0;
    fbms_station_model sm (.i_clk(i_clk), .i_present(present), .i_fire(fire),
        .o_online(onl), .o_exch(exch), .o_alarm(alm), .o_diag(dg));
    fbms_status_bank dut (.i_clk(i_clk), .i_reset(i_reset), .i_net_fault(i_net_fault),
        .i_station_expected(expct), .i_station_online(onl), .i_station_exchanging(exch),
        .i_alarm_raise(alm), .i_diag_raise(dg), .i_axi_awaddr(awaddr), .i_axi_awvalid(awv),
        .o_axi_awready(awr), .i_axi_wdata(wdata), .i_axi_wstrb(wstrb), .i_axi_wvalid(wv),
        .o_axi_wready(wr_rdy), .o_axi_bresp(bresp), .o_axi_bvalid(bv), .i_axi_bready(bready),
        .i_axi_araddr(araddr), .i_axi_arvalid(arv), .o_axi_arready(arr), .o_axi_rdata(rdata),
        .o_axi_rresp(rresp), .o_axi_rvalid(rv), .i_axi_rready(rready), .o_irq(irq));
    initial begin
        forever #20 i_clk = ~i_clk;
    end
    task test_done;
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // one watchdog for every wait: the handshake tasks never assume a latency
    always @(posedge i_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            test_done;
        end
    end
    task chk_data(input logic [31:0] g, input logic [31:0] e);
        n_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task chk_resp(input logic [1:0] g, input logic [1:0] e);
        n_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("BAD t=%0t resp got=%h exp=%h", $time, g, e);
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge i_clk);
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hF;
        awv <= 1;
        wv <= 1;
        bready <= 1;
        do @(posedge i_clk); while (awr !== 1'b1);
        awv <= 0;
        wv <= 0;
        while (bv !== 1'b1) @(posedge i_clk);
        r = bresp;
        bready <= 0;
    endtask
    task rdr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge i_clk);
        araddr <= a;
        arv <= 1;
        rready <= 1;
        do @(posedge i_clk); while (arr !== 1'b1);
        arv <= 0;
        while (rv !== 1'b1) @(posedge i_clk);
        d = rdata;
        r = rresp;
        rready <= 0;
    endtask
    task wr_ok(input logic [7:0] a, input logic [31:0] d);
        wr(a, d, rs);
        chk_resp(rs, FBMS_RESP_OKAY);
    endtask
    task rd_chk(input logic [7:0] a, input logic [31:0] e);
        rdr(a, rd, rs);
        chk_resp(rs, FBMS_RESP_OKAY);
        chk_data(rd, e);
    endtask
    function automatic logic [15:0] crc_w(input logic [15:0] c, input logic [31:0] w);
        for (int i = 31; i >= 0; i--)
            c = (c[15] ^ w[i]) ? {c[14:0], 1'b0} ^ FBMS_CRC_POLY : {c[14:0], 1'b0};
        return c;
    endfunction
    initial begin
        repeat (6) @(posedge i_clk);
        i_reset <= 0;
        rd_chk(FBMS_OFF_STATUS, 32'h00000004);
        rd_chk(FBMS_OFF_SIGNATURE, 32'h00000000);
        rd_chk(FBMS_OFF_IRQ_MASK, 32'h00000000);
        for (int m = 1; m < 5; m++) begin
            wr_ok(FBMS_OFF_CONTROL, 32'(m % 4));
            repeat (3) @(posedge i_clk);
            rd_chk(FBMS_OFF_STATUS, 32'h1 << (2 + m % 4));
        end
        wr_ok(FBMS_OFF_CONTROL, 32'h00000007);
        repeat (3) @(posedge i_clk);
        rd_chk(FBMS_OFF_STATUS, 32'h00000060);
        chk_data({31'h0, irq}, 32'h0);
        i_net_fault <= 1;
        expct <= 127'h2;
        present <= (127'h1 << 126) | 127'h7;
        repeat (4) @(posedge i_clk);
        rd_chk(FBMS_OFF_STATUS, 32'h00000063);
        rd_chk(FBMS_OFF_LIVE, 32'h00000007);
        rd_chk(FBMS_OFF_LIVE + 8'h0C, 32'h40000000);
        rd_chk(FBMS_OFF_EXCH, 32'h00000005);
        rd_chk(FBMS_OFF_EXCH + 8'h0C, 32'h40000000);
        rd_chk(FBMS_OFF_COUNT, 32'h00000003);
        wr_ok(FBMS_OFF_CONTROL, 32'h00000001);
        repeat (4) @(posedge i_clk);
        rd_chk(FBMS_OFF_EXCH, 32'h00000000);
        rd_chk(FBMS_OFF_COUNT, 32'h00000000);
        fire <= 1;
        @(posedge i_clk);
        fire <= 0;
        repeat (3) @(posedge i_clk);
        rd_chk(FBMS_OFF_ALARM, 32'h00000007);
        rd_chk(FBMS_OFF_ALARM + 8'h0C, 32'h40000000);
        rd_chk(FBMS_OFF_DIAG, 32'h00000007);
        rd_chk(FBMS_OFF_IRQ_STAT, 32'h0000001F);
        wr_ok(FBMS_OFF_IRQ_MASK, 32'h00000008);
        repeat (2) @(posedge i_clk);
        chk_data({31'h0, irq}, 32'h1);
        wr_ok(FBMS_OFF_IRQ_STAT, 32'h00000008);
        repeat (2) @(posedge i_clk);
        chk_data({31'h0, irq}, 32'h0);
        wr_ok(FBMS_OFF_ALARM, 32'h00000001);
        rd_chk(FBMS_OFF_ALARM, 32'h00000006);
        rd_chk(FBMS_OFF_DIAG + 8'h0C, 32'h40000000);
        wr_ok(FBMS_OFF_CFG_CMD, 32'h00000001);
        wr_ok(FBMS_OFF_CFG_DATA, 32'hA5C3_0F12);
        wr_ok(FBMS_OFF_CFG_CMD, 32'h00000002);
        crc = crc_w(FBMS_CRC_INIT, 32'hA5C3_0F12);
        repeat (2) @(posedge i_clk);
        rd_chk(FBMS_OFF_SIGNATURE, {16'h0, crc});
        rdr(8'h60, rd, rs);
        chk_resp(rs, FBMS_RESP_SLVERR);
        chk_data(rd, 32'h0);
        wr(8'h64, 32'hFFFFFFFF, rs);
        chk_resp(rs, FBMS_RESP_SLVERR);
        rd_chk(FBMS_OFF_STATUS, 32'h0000000B);
        test_done;
    end
endmodule // fbms_status_bank_tb

// file: hdl/fbms_crc16.sv
// fbms_crc16: running CRC-16 over configuration words, one 32-bit word per cycle
module fbms_crc16 import fbms_pkg::*; (
    input wire logic i_clk,
    input wire logic i_reset,
    fbms_crc_if.engine crc_bus
);
    typedef struct packed {
        logic [15:0] crc;
    } fbms_crc_s;

    fbms_crc_s state;
    fbms_crc_s next_state;

    function automatic logic [15:0] crc_word(input logic [15:0] c, input logic [31:0] w);
        logic [15:0] r;
        r = c;
        for (int i = 31; i >= 0; i--) begin
            r = (r[15] ^ w[i]) ? ((r << 1) ^ FBMS_CRC_POLY) : (r << 1);
        end
        return r;
    endfunction

    always_comb begin
        next_state = state;
        if (crc_bus.restart) begin
            next_state.crc = FBMS_CRC_INIT;
        end else if (crc_bus.word_valid) begin
            next_state.crc = crc_word(state.crc, crc_bus.word);
        end
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            state.crc <= FBMS_CRC_INIT;
        end else begin
            state <= next_state;
        end
    end

    assign crc_bus.crc = state.crc;
endmodule // fbms_crc16

// file: hdl/fbms_crc_if.sv
// fbms_crc_if: configuration words into the signature engine and its running checksum back
interface fbms_crc_if;
    logic restart;
    logic word_valid;
    logic [31:0] word;
    logic [15:0] crc;

    modport feeder (output restart, output word_valid, output word, input crc);
    modport engine (input restart, input word_valid, input word, output crc);
endinterface

// file: hdl/fbms_pkg.sv
// fbms_pkg: register map, field layout, modes and widths of the fieldbus master status bank
package fbms_pkg;
    localparam int FBMS_STATIONS = 127;
    localparam int FBMS_MAP_W = 128;
    localparam int FBMS_COUNT_W = 8;
    localparam int FBMS_ADDR_W = 8;
    localparam int FBMS_SIG_W = 16;
    localparam int FBMS_IRQ_W = 5;

    // byte offsets
    localparam logic [7:0] FBMS_OFF_STATUS = 8'h00;
    localparam logic [7:0] FBMS_OFF_CONTROL = 8'h04;
    localparam logic [7:0] FBMS_OFF_SIGNATURE = 8'h08;
    localparam logic [7:0] FBMS_OFF_COUNT = 8'h0C;
    localparam logic [7:0] FBMS_OFF_CFG_DATA = 8'h10;
    localparam logic [7:0] FBMS_OFF_CFG_CMD = 8'h14;
    localparam logic [7:0] FBMS_OFF_IRQ_STAT = 8'h18;
    localparam logic [7:0] FBMS_OFF_IRQ_MASK = 8'h1C;
    localparam logic [7:0] FBMS_OFF_LIVE = 8'h20;
    localparam logic [7:0] FBMS_OFF_EXCH = 8'h30;
    localparam logic [7:0] FBMS_OFF_ALARM = 8'h40;
    localparam logic [7:0] FBMS_OFF_DIAG = 8'h50;
    localparam logic [7:0] FBMS_MAP_SPAN = 8'h10;

    // module status word bits
    localparam int FBMS_ST_NET_ERR = 0;
    localparam int FBMS_ST_COMM_ERR = 1;
    localparam int FBMS_ST_OFFLINE = 2;
    localparam int FBMS_ST_STOPPED = 3;
    localparam int FBMS_ST_CLEAR = 4;
    localparam int FBMS_ST_OPERATE = 5;
    localparam int FBMS_ST_EMULATE = 6;

    // control register fields
    localparam int FBMS_CTL_MODE_LSB = 0;
    localparam int FBMS_CTL_EMU = 2;
    // configuration command bits
    localparam int FBMS_CMD_RESTART = 0;
    localparam int FBMS_CMD_COMMIT = 1;

    // interrupt status bits
    localparam int FBMS_IRQ_NET_ERR = 0;
    localparam int FBMS_IRQ_COMM_ERR = 1;
    localparam int FBMS_IRQ_MODE = 2;
    localparam int FBMS_IRQ_ALARM = 3;
    localparam int FBMS_IRQ_DIAG = 4;

    localparam logic [1:0] FBMS_RESP_OKAY = 2'h0;
    localparam logic [1:0] FBMS_RESP_SLVERR = 2'h2;

    localparam logic [15:0] FBMS_CRC_POLY = 16'h1021;
    localparam logic [15:0] FBMS_CRC_INIT = 16'hFFFF;
    localparam logic [15:0] FBMS_SIG_RESET = 16'h0000;

    typedef enum logic [1:0] {
        FBMS_MODE_OFFLINE,
        FBMS_MODE_STOPPED,
        FBMS_MODE_CLEAR,
        FBMS_MODE_OPERATE
    } fbms_mode_e;
endpackage

// file: hdl/fbms_status_bank.sv
// fbms_status_bank: fieldbus master status word, station bitmaps and AXI4-Lite access
// Summary of operation
// [R1] the network error flag is 1 while a cable or termination fault is detected, else 0.
// [R2] the slave error flag is 1 while an expected slave is not online and exchanging, else 0.
// [R3] the offline flag is 1 exactly while the master sits in its offline state.
// [R4] the stopped flag is 1 exactly while the master sits in its stopped state.
// [R5] the clear flag is 1 exactly while the master runs in clear mode.
// [R6] the operational flag is 1 exactly while the master runs operational, exchanging data.
// [R7] the emulation flag is 1 while the block emulates slave stations instead of mastering.
// [R8] the signature field holds the checksum of the configuration now in force.
// [R9] the active count gives how many stations are online and exchanging data.
// [R10] the live bitmap has one bit per station 0..126, 1 while that station is online.
// [R11] the exchange bitmap bit is 1 only while its station is online and exchanging cyclic data.
// [R12] the alarm bitmap bit is 1 while its station has an alarm waiting to be unloaded.
// [R13] the diagnostics bitmap bit is 1 while its station has diagnostics waiting to be unloaded.
// [R14] all single flags are gathered into one 32-bit status word mirroring them.
// [R15] at most one of the four mode flags is ever 1.
// [R16] no exchange bit exceeds its live bit, and the active count equals the exchange bits set.
module fbms_status_bank import fbms_pkg::*; #(
    parameter int STATIONS = FBMS_STATIONS
) (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_net_fault,
    input wire logic [STATIONS-1:0] i_station_expected,
    input wire logic [STATIONS-1:0] i_station_online,
    input wire logic [STATIONS-1:0] i_station_exchanging,
    input wire logic [STATIONS-1:0] i_alarm_raise,
    input wire logic [STATIONS-1:0] i_diag_raise,
    input wire logic [FBMS_ADDR_W-1:0] i_axi_awaddr,
    input wire logic i_axi_awvalid,
    output logic o_axi_awready,
    input wire logic [31:0] i_axi_wdata,
    input wire logic [3:0] i_axi_wstrb,
    input wire logic i_axi_wvalid,
    output logic o_axi_wready,
    output logic [1:0] o_axi_bresp,
    output logic o_axi_bvalid,
    input wire logic i_axi_bready,
    input wire logic [FBMS_ADDR_W-1:0] i_axi_araddr,
    input wire logic i_axi_arvalid,
    output logic o_axi_arready,
    output logic [31:0] o_axi_rdata,
    output logic [1:0] o_axi_rresp,
    output logic o_axi_rvalid,
    input wire logic i_axi_rready,
    output logic o_irq
);
    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        fbms_mode_e mode;
        logic [1:0] mode_req;
        logic emu_en;
        logic emulate;
        logic net_err;
        logic comm_err;
        logic [FBMS_SIG_W-1:0] signature;
        logic [FBMS_COUNT_W-1:0] count;
        logic [FBMS_MAP_W-1:0] live;
        logic [FBMS_MAP_W-1:0] exch;
        logic [FBMS_MAP_W-1:0] alarm;
        logic [FBMS_MAP_W-1:0] diag;
        logic [FBMS_IRQ_W-1:0] irq_stat;
        logic [FBMS_IRQ_W-1:0] irq_mask;
        logic irq;
        logic [31:0] cfg_word;
        logic cfg_valid;
        logic cfg_restart;
    } fbms_state_s;

    fbms_state_s state;
    fbms_state_s next_state;
    fbms_crc_if crc_bus ();

    logic [FBMS_MAP_W-1:0] expected_map;
    logic [FBMS_MAP_W-1:0] online_map;
    logic [FBMS_MAP_W-1:0] exchanging_map;
    logic [FBMS_MAP_W-1:0] alarm_raise_map;
    logic [FBMS_MAP_W-1:0] diag_raise_map;

    // stations from STATIONS upward stay zero in every map
    assign expected_map = FBMS_MAP_W'(i_station_expected);
    assign online_map = FBMS_MAP_W'(i_station_online);
    assign exchanging_map = FBMS_MAP_W'(i_station_exchanging);
    assign alarm_raise_map = FBMS_MAP_W'(i_alarm_raise);
    assign diag_raise_map = FBMS_MAP_W'(i_diag_raise);

    function automatic logic [31:0] map_word(input logic [FBMS_MAP_W-1:0] m,
                                             input logic [1:0] idx);
        return m[32*idx +: 32];
    endfunction

    function automatic logic [31:0] strobe_mask(input logic [3:0] strb);
        logic [31:0] r;
        for (int b = 0; b < 4; b++) begin
            r[8*b +: 8] = {8{strb[b]}};
        end
        return r;
    endfunction

    function automatic logic [FBMS_COUNT_W-1:0] pop_count(input logic [FBMS_MAP_W-1:0] m);
        logic [FBMS_COUNT_W-1:0] n;
        n = '0;
        for (int i = 0; i < FBMS_MAP_W; i++) begin
            n = n + FBMS_COUNT_W'(m[i]);
        end
        return n;
    endfunction

    function automatic logic in_map(input logic [FBMS_ADDR_W-1:0] a, input logic [7:0] base);
        return (a >= base) && (a < base + FBMS_MAP_SPAN);
    endfunction

    function automatic logic [31:0] status_word(input fbms_state_s s);
        logic [31:0] w;
        w = '0;
        w[FBMS_ST_NET_ERR] = s.net_err; // [R14]
        w[FBMS_ST_COMM_ERR] = s.comm_err;
        w[FBMS_ST_OFFLINE] = (s.mode == FBMS_MODE_OFFLINE);
        w[FBMS_ST_STOPPED] = (s.mode == FBMS_MODE_STOPPED);
        w[FBMS_ST_CLEAR] = (s.mode == FBMS_MODE_CLEAR);
        w[FBMS_ST_OPERATE] = (s.mode == FBMS_MODE_OPERATE);
        w[FBMS_ST_EMULATE] = s.emulate;
        return w;
    endfunction

    logic wr_go;
    logic [31:0] wr_mask;
    logic [31:0] wr_bits;
    logic [1:0] wr_word;
    logic [1:0] rd_word;
    logic data_moving;

    assign wr_go = state.awready && state.wready;
    assign wr_mask = strobe_mask(i_axi_wstrb);
    assign wr_bits = i_axi_wdata & wr_mask;
    assign wr_word = i_axi_awaddr[3:2];
    assign rd_word = i_axi_araddr[3:2];

    always_comb begin
        logic [FBMS_MAP_W-1:0] alarm_clr;
        logic [FBMS_MAP_W-1:0] diag_clr;
        logic [FBMS_IRQ_W-1:0] irq_clr;
        logic [FBMS_IRQ_W-1:0] irq_set;
        alarm_clr = '0;
        diag_clr = '0;
        irq_clr = '0;
        irq_set = '0;
        next_state = state;
        next_state.cfg_valid = 1'b0;
        next_state.cfg_restart = 1'b0;

        // write channel: address and data taken together, response after both
        next_state.awready = !state.awready && !state.bvalid && i_axi_awvalid && i_axi_wvalid;
        next_state.wready = next_state.awready;
        if (state.bvalid && i_axi_bready) begin
            next_state.bvalid = 1'b0;
        end
        if (wr_go) begin
            next_state.bvalid = 1'b1;
            next_state.bresp = FBMS_RESP_OKAY;
            if (i_axi_awaddr == FBMS_OFF_CONTROL) begin
                if (i_axi_wstrb[0]) begin
                    next_state.mode_req = i_axi_wdata[FBMS_CTL_MODE_LSB +: 2];
                    next_state.emu_en = i_axi_wdata[FBMS_CTL_EMU];
                end
            end else if (i_axi_awaddr == FBMS_OFF_CFG_DATA) begin
                next_state.cfg_word = i_axi_wdata;
                next_state.cfg_valid = 1'b1;
            end else if (i_axi_awaddr == FBMS_OFF_CFG_CMD) begin
                next_state.cfg_restart = wr_bits[FBMS_CMD_RESTART];
                if (wr_bits[FBMS_CMD_COMMIT]) begin
                    next_state.signature = crc_bus.crc; // [R8]
                end
            end else if (i_axi_awaddr == FBMS_OFF_IRQ_STAT) begin
                irq_clr = wr_bits[FBMS_IRQ_W-1:0];
            end else if (i_axi_awaddr == FBMS_OFF_IRQ_MASK) begin
                next_state.irq_mask = (state.irq_mask & ~wr_mask[FBMS_IRQ_W-1:0])
                                    | wr_bits[FBMS_IRQ_W-1:0];
            end else if (in_map(i_axi_awaddr, FBMS_OFF_ALARM)) begin
                alarm_clr[32*wr_word +: 32] = wr_bits;
            end else if (in_map(i_axi_awaddr, FBMS_OFF_DIAG)) begin
                diag_clr[32*wr_word +: 32] = wr_bits;
            end else if (i_axi_awaddr != FBMS_OFF_STATUS && i_axi_awaddr != FBMS_OFF_SIGNATURE
                         && i_axi_awaddr != FBMS_OFF_COUNT
                         && !in_map(i_axi_awaddr, FBMS_OFF_LIVE)
                         && !in_map(i_axi_awaddr, FBMS_OFF_EXCH)) begin
                next_state.bresp = FBMS_RESP_SLVERR;
            end
        end

        // master state follows the requested mode; one state keeps the flags exclusive
        case (state.mode_req)
            2'h0: next_state.mode = FBMS_MODE_OFFLINE; // [R3] [R15]
            2'h1: next_state.mode = FBMS_MODE_STOPPED; // [R4]
            2'h2: next_state.mode = FBMS_MODE_CLEAR; // [R5]
            2'h3: next_state.mode = FBMS_MODE_OPERATE; // [R6]
            default: next_state.mode = FBMS_MODE_OFFLINE;
        endcase
        next_state.emulate = state.emu_en; // [R7]
        next_state.net_err = i_net_fault; // [R1]

        next_state.live = online_map; // [R10]
        // cyclic data only moves in clear or operate; stations must also be live
        data_moving = (state.mode == FBMS_MODE_CLEAR) || (state.mode == FBMS_MODE_OPERATE);
        next_state.exch = {FBMS_MAP_W{data_moving}} & online_map & exchanging_map; // [R11] [R16]
        next_state.count = pop_count(next_state.exch); // [R9] [R16]
        next_state.comm_err = |(expected_map & ~state.exch); // [R2]

        // a raise in the same cycle as an unload wins
        next_state.alarm = (state.alarm & ~alarm_clr) | alarm_raise_map; // [R12]
        next_state.diag = (state.diag & ~diag_clr) | diag_raise_map; // [R13]

        irq_set[FBMS_IRQ_NET_ERR] = next_state.net_err && !state.net_err;
        irq_set[FBMS_IRQ_COMM_ERR] = next_state.comm_err && !state.comm_err;
        irq_set[FBMS_IRQ_MODE] = next_state.mode != state.mode;
        irq_set[FBMS_IRQ_ALARM] = |alarm_raise_map;
        irq_set[FBMS_IRQ_DIAG] = |diag_raise_map;
        next_state.irq_stat = (state.irq_stat & ~irq_clr) | irq_set;
        next_state.irq = |(next_state.irq_stat & next_state.irq_mask);

        // read channel: one read at a time, data registered with rvalid
        next_state.arready = !state.arready && !state.rvalid && i_axi_arvalid;
        if (state.rvalid && i_axi_rready) begin
            next_state.rvalid = 1'b0;
        end
        if (state.arready) begin
            next_state.rvalid = 1'b1;
            next_state.rresp = FBMS_RESP_OKAY;
            next_state.rdata = '0;
            if (i_axi_araddr == FBMS_OFF_STATUS) begin
                next_state.rdata = status_word(state);
            end else if (i_axi_araddr == FBMS_OFF_CONTROL) begin
                next_state.rdata[FBMS_CTL_MODE_LSB +: 2] = state.mode_req;
                next_state.rdata[FBMS_CTL_EMU] = state.emu_en;
            end else if (i_axi_araddr == FBMS_OFF_SIGNATURE) begin
                next_state.rdata[FBMS_SIG_W-1:0] = state.signature;
            end else if (i_axi_araddr == FBMS_OFF_COUNT) begin
                next_state.rdata[FBMS_COUNT_W-1:0] = state.count;
            end else if (i_axi_araddr == FBMS_OFF_IRQ_STAT) begin
                next_state.rdata[FBMS_IRQ_W-1:0] = state.irq_stat;
            end else if (i_axi_araddr == FBMS_OFF_IRQ_MASK) begin
                next_state.rdata[FBMS_IRQ_W-1:0] = state.irq_mask;
            end else if (in_map(i_axi_araddr, FBMS_OFF_LIVE)) begin
                next_state.rdata = map_word(state.live, rd_word);
            end else if (in_map(i_axi_araddr, FBMS_OFF_EXCH)) begin
                next_state.rdata = map_word(state.exch, rd_word);
            end else if (in_map(i_axi_araddr, FBMS_OFF_ALARM)) begin
                next_state.rdata = map_word(state.alarm, rd_word);
            end else if (in_map(i_axi_araddr, FBMS_OFF_DIAG)) begin
                next_state.rdata = map_word(state.diag, rd_word);
            end else if (i_axi_araddr != FBMS_OFF_CFG_DATA && i_axi_araddr != FBMS_OFF_CFG_CMD) begin
                next_state.rresp = FBMS_RESP_SLVERR;
            end
        end
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            state <= '0;
            state.mode <= FBMS_MODE_OFFLINE;
            state.signature <= FBMS_SIG_RESET;
        end else begin
            state <= next_state;
        end
    end

    assign crc_bus.restart = state.cfg_restart;
    assign crc_bus.word_valid = state.cfg_valid;
    assign crc_bus.word = state.cfg_word;

    fbms_crc16 u_crc (
        .i_clk(i_clk),
        .i_reset(i_reset),
        .crc_bus(crc_bus)
    );

    assign o_axi_awready = state.awready;
    assign o_axi_wready = state.wready;
    assign o_axi_bresp = state.bresp;
    assign o_axi_bvalid = state.bvalid;
    assign o_axi_arready = state.arready;
    assign o_axi_rdata = state.rdata;
    assign o_axi_rresp = state.rresp;
    assign o_axi_rvalid = state.rvalid;
    assign o_irq = state.irq;

    // flat views of registered state for the checkers below
    logic [31:0] status_now;
    logic comm_err_cause;
    assign status_now = status_word(state);
    assign comm_err_cause = |(expected_map & ~state.exch);

    net_err_track_a: assert property (@(posedge i_clk) disable iff (i_reset) // [R1]
        i_net_fault |=> state.net_err) else $error("network error flag missed a fault");
    net_err_quiet_a: assert property (@(posedge i_clk) disable iff (i_reset) // [R1]
        !i_net_fault ##1 !i_net_fault |-> !state.net_err) else $error("network flag set without fault");
    comm_err_cause_a: assert property (@(posedge i_clk) disable iff (i_reset) // [R2]
        state.comm_err == $past(comm_err_cause)) else $error("slave error flag wrong");
    comm_err_clear_a: assert property (@(posedge i_clk) disable iff (i_reset) // [R2]
        !comm_err_cause |=> !state.comm_err) else $error("slave error flag stuck");
    offline_follow_a: assert property (@(posedge i_clk) disable iff (i_reset) // [R3]
        (state.mode_req == 2'h0) [*2] |-> status_now[FBMS_ST_OFFLINE])
        else $error("offline flag not raised");
    stopped_follow_a: assert property (@(posedge i_clk) disable iff (i_reset) // [R4]
        (state.mode_req == 2'h1) [*2] |-> status_now[FBMS_ST_STOPPED])
        else $error("stopped flag not raised");
    clear_follow_a: assert property (@(posedge i_clk) disable iff (i_reset) // [R5]
        (state.mode_req == 2'h2) [*2] |-> status_now[FBMS_ST_CLEAR])
        else $error("clear flag not raised");
    operate_follow_a: assert property (@(posedge i_clk) disable iff (i_reset) // [R6]
        (state.mode_req == 2'h3) [*2] |-> status_now[FBMS_ST_OPERATE])
        else $error("operational flag not raised");
    emulate_follow_a: assert property (@(posedge i_clk) disable iff (i_reset) // [R7]
        $changed(state.emu_en) |=> state.emulate == $past(state.emu_en))
        else $error("emulation flag lags control");
    signature_commit_a: assert property (@(posedge i_clk) disable iff (i_reset) // [R8]
        wr_go && i_axi_awaddr == FBMS_OFF_CFG_CMD && wr_bits[FBMS_CMD_COMMIT]
        |=> state.signature == $past(crc_bus.crc)) else $error("signature not committed");
    live_follow_a: assert property (@(posedge i_clk) disable iff (i_reset) // [R10]
        1'b1 |=> state.live == $past(online_map)) else $error("live bitmap stale");
    exch_gate_a: assert property (@(posedge i_clk) disable iff (i_reset) // [R11]
        !data_moving |=> state.exch == '0) else $error("exchange bit outside data modes");
    alarm_sticky_a: assert property (@(posedge i_clk) disable iff (i_reset) // [R12]
        |alarm_raise_map |=> (state.alarm & $past(alarm_raise_map)) == $past(alarm_raise_map))
        else $error("alarm raise lost");
    diag_sticky_a: assert property (@(posedge i_clk) disable iff (i_reset) // [R13]
        |diag_raise_map |=> (state.diag & $past(diag_raise_map)) == $past(diag_raise_map))
        else $error("diagnostics raise lost");
    mode_exclusive_a: assert property (@(posedge i_clk) disable iff (i_reset) // [R15]
        $onehot0(status_now[FBMS_ST_OPERATE:FBMS_ST_OFFLINE]))
        else $error("more than one mode flag");
    exch_count_a: assert property (@(posedge i_clk) disable iff (i_reset) // [R16]
        ((state.exch & ~state.live) == '0) && (state.count == pop_count(state.exch)))
        else $error("exchange map or count inconsistent");
endmodule // fbms_status_bank
